// >>> mmlc_top.sv
`timescale 1ns/1ps
`default_nettype none
module mmlc_top (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe_n,
  input  wire logic        i_write_protect_pin,
  input  wire logic        i_meas_valid,
  input  wire logic [15:0] i_temp,
  input  wire logic [15:0] i_vcc,
  input  wire logic [15:0] i_ext_input_one,
  input  wire logic [15:0] i_ext_input_two,
  input  wire logic [15:0] i_ext_input_three,
  output logic [7:0]       o_res0_pos,
  output logic [7:0]       o_res1_pos,
  output logic             o_manual_mode
);
  mmlc_mem_if mif ();
  mmlc_mem u_mem (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .mem(mif.mem));

  // serial link state
  mmlc_pkg::mmlc_state_type st_ff, nxt_st;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] ptr_ff, nxt_ptr;
  logic       first_ff, nxt_first;
  logic       wptr_ff, nxt_wptr;
  logic       is_main_ff, nxt_is_main;
  logic       rd_ff, nxt_rd;
  logic       acked_ff, nxt_acked;
  logic       oe_n_ff, nxt_oe_n;
  logic       scl_d_ff, sda_d_ff;
  logic       scl_rise, scl_fall, start_cond, stop_cond;
  // shadows of memory bytes that steer logic
  logic [7:0] lim_ff [mmlc_pkg::LIMIT_BYTES];
  logic [7:0] nxt_lim [mmlc_pkg::LIMIT_BYTES];
  logic [7:0] tbl_ff, nxt_tbl, cfg_ff, nxt_cfg, dev_ff, nxt_dev, man0_ff, nxt_man0, man1_ff, nxt_man1;
  logic [15:0] m_temp_ff, m_vcc_ff, m_ext_input_one_ff, m_ext_input_two_ff, m_ext_input_three_ff;
  logic [7:0]  alarm_ff, nxt_alarm, warn_ff, nxt_warn;
  logic [7:0]  pos0_ff, nxt_pos0, pos1_ff, nxt_pos1;
  logic        lut_sel_ff, lut_sel_d_ff;
  // decode
  logic [2:0] blk;
  logic       mapped, ro_loc, wr_ok, main_prot, byte_done, addr_hit_aux, addr_hit_main;
  logic [7:0] main_addr, rd_byte, ro_byte;
  logic [6:0] lut_idx;
  logic signed [8:0] t_deg, t_sum;

  assign scl_rise   = i_scl & ~scl_d_ff;
  assign scl_fall   = ~i_scl & scl_d_ff;
  assign start_cond = scl_d_ff & i_scl & sda_d_ff & ~i_sda;
  assign stop_cond  = scl_d_ff & i_scl & ~sda_d_ff & i_sda;
  assign byte_done  = scl_fall && (bit_cnt_ff == mmlc_pkg::BITS_PER_BYTE);

  // device address matching
  always_comb begin
    main_addr     = cfg_ff[mmlc_pkg::CFG_PROGRAMMABLE_ADDRESS_SELECT] ? dev_ff : mmlc_pkg::MAIN_DEV_DFLT;
    addr_hit_main = shift_ff[7:1] == main_addr[7:1];
    addr_hit_aux  = !cfg_ff[mmlc_pkg::CFG_SINGLE_ADDRESS_SELECT] && (shift_ff[7:1] == mmlc_pkg::AUX_DEV_ADDR[7:1]);
  end

  // map pointer onto storage blocks
  always_comb begin
    blk    = mmlc_pkg::BLK_AUX;
    mapped = 1'b1;
    if (!is_main_ff) begin
      blk = mmlc_pkg::BLK_AUX;
    end else if (ptr_ff < mmlc_pkg::BANK_BASE) begin
      blk = mmlc_pkg::BLK_LOW;
    end else begin
      case (tbl_ff)
        mmlc_pkg::TBL_00: blk = mmlc_pkg::BLK_AUX;
        mmlc_pkg::TBL_01: blk = mmlc_pkg::BLK_T1;
        mmlc_pkg::TBL_02: blk = mmlc_pkg::BLK_T2;
        mmlc_pkg::TBL_03: blk = mmlc_pkg::BLK_T3;
        default:          mapped = 1'b0;
      endcase
    end
    ro_loc    = (blk == mmlc_pkg::BLK_LOW) && (ptr_ff >= mmlc_pkg::RO_FIRST) && (ptr_ff <= mmlc_pkg::RO_LAST);
    // open pin reads high through the pull-up; grounded pin never protects
    main_prot = i_write_protect_pin && cfg_ff[mmlc_pkg::CFG_MAIN_PROTECT_BIT];
    if (blk == mmlc_pkg::BLK_AUX) begin
      wr_ok = mapped && !cfg_ff[mmlc_pkg::CFG_AUX_PROTECT_BIT];
    end else begin
      wr_ok = mapped && !ro_loc && !main_prot;
    end
  end

  // read-only sram locations, msb at even address
  always_comb begin
    case (ptr_ff)
      mmlc_pkg::MEAS_TEMP_OFS:       ro_byte = m_temp_ff[15:8];
      mmlc_pkg::MEAS_TEMP_OFS + 8'h01: ro_byte = m_temp_ff[7:0];
      mmlc_pkg::MEAS_VCC_OFS:        ro_byte = m_vcc_ff[15:8];
      mmlc_pkg::MEAS_VCC_OFS + 8'h01:  ro_byte = m_vcc_ff[7:0];
      mmlc_pkg::MEAS_EXT_INPUT_ONE_OFS:       ro_byte = m_ext_input_one_ff[15:8];
      mmlc_pkg::MEAS_EXT_INPUT_ONE_OFS + 8'h01: ro_byte = m_ext_input_one_ff[7:0];
      mmlc_pkg::MEAS_EXT_INPUT_TWO_OFS:       ro_byte = m_ext_input_two_ff[15:8];
      mmlc_pkg::MEAS_EXT_INPUT_TWO_OFS + 8'h01: ro_byte = m_ext_input_two_ff[7:0];
      mmlc_pkg::MEAS_EXT_INPUT_THREE_OFS:       ro_byte = m_ext_input_three_ff[15:8];
      mmlc_pkg::MEAS_EXT_INPUT_THREE_OFS + 8'h01: ro_byte = m_ext_input_three_ff[7:0];
      mmlc_pkg::ALARM_FLAG_OFS:      ro_byte = alarm_ff;
      mmlc_pkg::WARN_FLAG_OFS:       ro_byte = warn_ff;
      default:                       ro_byte = 8'h00;
    endcase
    if (!mapped) begin
      rd_byte = mmlc_pkg::UNMAPPED_READ;
    end else if (ro_loc) begin
      rd_byte = ro_byte;
    end else begin
      rd_byte = mif.bus_rdata;
    end
  end

  assign mif.bus_addr  = {blk, ptr_ff[6:0]};
  assign mif.bus_wdata = shift_ff;
  assign mif.bus_we    = (st_ff == mmlc_pkg::ST_RX) && byte_done && !first_ff && !wptr_ff && !rd_ff && wr_ok;

  // serial slave sequencing
  always_comb begin
    nxt_st      = st_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift   = shift_ff;
    nxt_ptr     = ptr_ff;
    nxt_first   = first_ff;
    nxt_wptr    = wptr_ff;
    nxt_is_main = is_main_ff;
    nxt_rd      = rd_ff;
    nxt_acked   = acked_ff;
    nxt_oe_n    = oe_n_ff;
    if (stop_cond) begin
      nxt_st   = mmlc_pkg::ST_IDLE;
      nxt_oe_n = 1'b1;
    end else if (start_cond) begin
      nxt_st      = mmlc_pkg::ST_RX;
      nxt_bit_cnt = 4'h0;
      nxt_first   = 1'b1;
      nxt_oe_n    = 1'b1;
    end else begin
      unique case (st_ff)
        mmlc_pkg::ST_IDLE: begin
          nxt_oe_n = 1'b1;
        end
        mmlc_pkg::ST_RX: begin
          if (scl_rise && bit_cnt_ff < mmlc_pkg::BITS_PER_BYTE) begin
            nxt_shift   = {shift_ff[6:0], i_sda};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (byte_done) begin
            nxt_st   = mmlc_pkg::ST_ACK;
            nxt_oe_n = 1'b0;
            if (first_ff) begin
              nxt_first   = 1'b0;
              nxt_wptr    = ~shift_ff[0];
              nxt_rd      = shift_ff[0];
              nxt_is_main = addr_hit_main;
              if (!(addr_hit_main || addr_hit_aux)) begin
                nxt_st   = mmlc_pkg::ST_IDLE;
                nxt_oe_n = 1'b1;
              end
            end else if (wptr_ff) begin
              nxt_wptr = 1'b0;
              nxt_ptr  = shift_ff;
            end else begin
              nxt_ptr = ptr_ff + 8'h01;
            end
          end
        end
        mmlc_pkg::ST_ACK: begin
          if (scl_fall) begin
            nxt_bit_cnt = 4'h0;
            if (rd_ff) begin
              nxt_st    = mmlc_pkg::ST_TX;
              nxt_shift = rd_byte;
              nxt_oe_n  = rd_byte[7];
            end else begin
              nxt_st   = mmlc_pkg::ST_RX;
              nxt_oe_n = 1'b1;
            end
          end
        end
        mmlc_pkg::ST_TX: begin
          if (scl_fall) begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            nxt_shift   = {shift_ff[6:0], 1'b0};
            nxt_oe_n    = shift_ff[6];
            if (bit_cnt_ff == mmlc_pkg::BITS_PER_BYTE - 4'h1) begin
              nxt_st   = mmlc_pkg::ST_RACK;
              nxt_oe_n = 1'b1;
            end
          end
        end
        mmlc_pkg::ST_RACK: begin
          if (scl_rise) begin
            nxt_acked = ~i_sda;
            if (!i_sda) begin
              nxt_ptr = ptr_ff + 8'h01;
            end
          end else if (scl_fall) begin
            nxt_bit_cnt = 4'h0;
            if (acked_ff) begin
              // pointer moved at the rising edge, read data settled since
              nxt_st    = mmlc_pkg::ST_TX;
              nxt_shift = rd_byte;
              nxt_oe_n  = rd_byte[7];
            end else begin
              nxt_st = mmlc_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          nxt_st   = mmlc_pkg::ST_IDLE;
          nxt_oe_n = 1'b1;
        end
      endcase
    end
  end

  // shadows follow accepted writes
  always_comb begin
    for (int i = 0; i < mmlc_pkg::LIMIT_BYTES; i++) begin
      nxt_lim[i] = lim_ff[i];
    end
    nxt_tbl  = tbl_ff;
    nxt_cfg  = cfg_ff;
    nxt_dev  = dev_ff;
    nxt_man0 = man0_ff;
    nxt_man1 = man1_ff;
    if (mif.bus_we && blk == mmlc_pkg::BLK_LOW) begin
      if (ptr_ff < 8'(mmlc_pkg::LIMIT_BYTES)) begin
        nxt_lim[ptr_ff[4:0]] = shift_ff;
      end
      if (ptr_ff == mmlc_pkg::TBL_SEL_OFS) begin
        nxt_tbl = shift_ff;
      end
    end
    if (mif.bus_we && blk == mmlc_pkg::BLK_T1) begin
      if (ptr_ff == mmlc_pkg::CFG_OFS) begin
        nxt_cfg = shift_ff;
      end
      if (ptr_ff == mmlc_pkg::ADDR_OFS) begin
        nxt_dev = shift_ff;
      end
      if (ptr_ff == mmlc_pkg::MAN_POS0_OFS) begin
        nxt_man0 = shift_ff;
      end
      if (ptr_ff == mmlc_pkg::MAN_POS1_OFS) begin
        nxt_man1 = shift_ff;
      end
    end
  end

  // limit comparison on the stored readings, redone every cycle
  logic [4:0] ch_above, ch_below;
  logic [15:0] ch_val [5];
  logic [4:0]  ch_hi_ofs [5];
  logic [4:0]  ch_lo_ofs [5];
  assign ch_val    = '{m_temp_ff, m_temp_ff, m_vcc_ff, m_vcc_ff, m_ext_input_one_ff};
  assign ch_hi_ofs = '{mmlc_pkg::LIM_T_AHI, mmlc_pkg::LIM_T_WHI, mmlc_pkg::LIM_V_AHI, mmlc_pkg::LIM_V_WHI,
                       mmlc_pkg::LIM_M1_AHI};
  // only the first external-input limit is held; its low side never trips
  assign ch_lo_ofs = '{mmlc_pkg::LIM_T_ALO, mmlc_pkg::LIM_T_WLO, mmlc_pkg::LIM_V_ALO, mmlc_pkg::LIM_V_WLO,
                       mmlc_pkg::LIM_T_ALO};
  generate
    for (genvar c = 0; c < 5; c++) begin : g_cmp
      mmlc_lim_cmp u_cmp (
        .i_signed (c < 2),
        .i_value  (ch_val[c]),
        .i_high   ({lim_ff[ch_hi_ofs[c]], lim_ff[ch_hi_ofs[c] + 5'h01]}),
        .i_low    ({lim_ff[ch_lo_ofs[c]], lim_ff[ch_lo_ofs[c] + 5'h01]}),
        .o_above  (ch_above[c]),
        .o_below  (ch_below[c])
      );
    end
  endgenerate

  always_comb begin
    nxt_alarm = 8'h00;
    nxt_warn  = 8'h00;
    nxt_alarm[mmlc_pkg::FLG_TEMP_HI] = ch_above[0];
    nxt_alarm[mmlc_pkg::FLG_TEMP_LO] = ch_below[0];
    nxt_alarm[mmlc_pkg::FLG_VCC_HI]  = ch_above[2];
    nxt_alarm[mmlc_pkg::FLG_VCC_LO]  = ch_below[2];
    nxt_alarm[mmlc_pkg::FLG_EXT_INPUT_ONE_HI] = ch_above[4];
    nxt_warn[mmlc_pkg::FLG_TEMP_HI]  = ch_above[1];
    nxt_warn[mmlc_pkg::FLG_TEMP_LO]  = ch_below[1];
    nxt_warn[mmlc_pkg::FLG_VCC_HI]   = ch_above[3];
    nxt_warn[mmlc_pkg::FLG_VCC_LO]   = ch_below[3];
  end

  // temperature to lookup index, clamped at both ends
  always_comb begin
    t_deg = {m_temp_ff[15], m_temp_ff[15:8]};
    t_sum = t_deg + mmlc_pkg::TEMP_BIAS;
    if (t_deg < mmlc_pkg::TEMP_MIN) begin
      lut_idx = 7'h00;
    end else if (t_deg > mmlc_pkg::TEMP_MAX) begin
      lut_idx = mmlc_pkg::LUT_IDX_LAST;
    end else begin
      lut_idx = t_sum[7:1];
    end
  end
  // resistors alternate on one lookup port: each position refreshes every two cycles
  assign mif.lut_addr = {lut_sel_ff ? mmlc_pkg::BLK_T3 : mmlc_pkg::BLK_T2, lut_idx};

  always_comb begin
    nxt_pos0 = pos0_ff;
    nxt_pos1 = pos1_ff;
    if (!cfg_ff[mmlc_pkg::CFG_TEN]) begin
      nxt_pos0 = man0_ff;
      nxt_pos1 = man1_ff;
    end else if (lut_sel_d_ff) begin
      nxt_pos1 = mif.lut_rdata;
    end else begin
      nxt_pos0 = mif.lut_rdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= mmlc_pkg::ST_IDLE;
      {bit_cnt_ff, shift_ff, ptr_ff} <= '0;
      {first_ff, wptr_ff, is_main_ff, rd_ff, acked_ff} <= '0;
      oe_n_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      for (int i = 0; i < mmlc_pkg::LIMIT_BYTES; i++) begin
        lim_ff[i] <= 8'h00;
      end
      {tbl_ff, cfg_ff, man0_ff, man1_ff} <= '0;
      dev_ff <= mmlc_pkg::MAIN_DEV_DFLT;
      {m_temp_ff, m_vcc_ff, m_ext_input_one_ff, m_ext_input_two_ff, m_ext_input_three_ff} <= '0;
      {alarm_ff, warn_ff, pos0_ff, pos1_ff} <= '0;
      {lut_sel_ff, lut_sel_d_ff} <= '0;
    end else begin
      st_ff <= nxt_st;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      {first_ff, wptr_ff, is_main_ff, rd_ff, acked_ff} <= {nxt_first, nxt_wptr, nxt_is_main, nxt_rd, nxt_acked};
      oe_n_ff <= nxt_oe_n;
      scl_d_ff <= i_scl;
      sda_d_ff <= i_sda;
      lim_ff <= nxt_lim;
      {tbl_ff, cfg_ff, dev_ff, man0_ff, man1_ff} <= {nxt_tbl, nxt_cfg, nxt_dev, nxt_man0, nxt_man1};
      if (i_meas_valid) begin
        {m_temp_ff, m_vcc_ff, m_ext_input_one_ff} <= {i_temp, i_vcc, i_ext_input_one};
        {m_ext_input_two_ff, m_ext_input_three_ff} <= {i_ext_input_two, i_ext_input_three};
      end
      {alarm_ff, warn_ff, pos0_ff, pos1_ff} <= {nxt_alarm, nxt_warn, nxt_pos0, nxt_pos1};
      lut_sel_ff <= ~lut_sel_ff;
      lut_sel_d_ff <= lut_sel_ff;
    end
  end

  assign o_sda         = 1'b0;
  assign o_sda_oe_n    = oe_n_ff;
  assign o_res0_pos    = pos0_ff;
  assign o_res1_pos    = pos1_ff;
  assign o_manual_mode = ~cfg_ff[mmlc_pkg::CFG_TEN];
endmodule
`default_nettype wire

// >>> mmlc_pkg.sv
package mmlc_pkg;
  // device addresses, low bit of the address byte is the read flag
  localparam logic [7:0] AUX_DEV_ADDR   = 8'ha0;
  localparam logic [7:0] MAIN_DEV_DFLT  = 8'ha2;
  // main map locations
  localparam logic [7:0] TBL_SEL_OFS    = 8'h7f;
  localparam logic [7:0] BANK_BASE      = 8'h80;
  localparam logic [7:0] MAN_POS0_OFS   = 8'h82;
  localparam logic [7:0] MAN_POS1_OFS   = 8'h83;
  localparam logic [7:0] CFG_OFS        = 8'h89;
  localparam logic [7:0] ADDR_OFS       = 8'h8c;
  localparam logic [7:0] RO_FIRST       = 8'h60;
  localparam logic [7:0] RO_LAST        = 8'h77;
  localparam logic [7:0] MEAS_TEMP_OFS  = 8'h60;
  localparam logic [7:0] MEAS_VCC_OFS   = 8'h62;
  localparam logic [7:0] MEAS_EXT_INPUT_ONE_OFS  = 8'h64;
  localparam logic [7:0] MEAS_EXT_INPUT_TWO_OFS  = 8'h66;
  localparam logic [7:0] MEAS_EXT_INPUT_THREE_OFS  = 8'h68;
  localparam logic [7:0] ALARM_FLAG_OFS = 8'h70;
  localparam logic [7:0] WARN_FLAG_OFS  = 8'h74;
  localparam logic [7:0] UNMAPPED_READ  = 8'hff;
  // limit bytes 00h..11h, msb at the even location
  localparam int unsigned LIMIT_BYTES   = 18;
  localparam logic [4:0] LIM_T_AHI      = 5'h00;
  localparam logic [4:0] LIM_T_ALO      = 5'h02;
  localparam logic [4:0] LIM_T_WHI      = 5'h04;
  localparam logic [4:0] LIM_T_WLO      = 5'h06;
  localparam logic [4:0] LIM_V_AHI      = 5'h08;
  localparam logic [4:0] LIM_V_ALO      = 5'h0a;
  localparam logic [4:0] LIM_V_WHI      = 5'h0c;
  localparam logic [4:0] LIM_V_WLO      = 5'h0e;
  localparam logic [4:0] LIM_M1_AHI     = 5'h10;
  // configuration byte fields
  localparam int unsigned CFG_TEN       = 0;
  localparam int unsigned CFG_PROGRAMMABLE_ADDRESS_SELECT     = 1;
  localparam int unsigned CFG_SINGLE_ADDRESS_SELECT      = 2;
  localparam int unsigned CFG_AUX_PROTECT_BIT      = 3;
  localparam int unsigned CFG_MAIN_PROTECT_BIT      = 4;
  // flag byte fields
  localparam int unsigned FLG_TEMP_HI   = 7;
  localparam int unsigned FLG_TEMP_LO   = 6;
  localparam int unsigned FLG_VCC_HI    = 5;
  localparam int unsigned FLG_VCC_LO    = 4;
  localparam int unsigned FLG_EXT_INPUT_ONE_HI   = 3;
  // temperature index
  localparam logic signed [8:0] TEMP_MIN  = -9'sd40;
  localparam logic signed [8:0] TEMP_MAX  = 9'sd102;
  localparam logic signed [8:0] TEMP_BIAS = 9'sd40;
  localparam logic [6:0] LUT_IDX_LAST     = 7'h47;
  // storage blocks of 128 bytes
  localparam int unsigned MEM_AW        = 10;
  localparam int unsigned MEM_WORDS     = 640;
  localparam logic [2:0] BLK_AUX        = 3'h0;
  localparam logic [2:0] BLK_LOW        = 3'h1;
  localparam logic [2:0] BLK_T1         = 3'h2;
  localparam logic [2:0] BLK_T2         = 3'h3;
  localparam logic [2:0] BLK_T3         = 3'h4;
  localparam logic [7:0] TBL_00         = 8'h00;
  localparam logic [7:0] TBL_01         = 8'h01;
  localparam logic [7:0] TBL_02         = 8'h02;
  localparam logic [7:0] TBL_03         = 8'h03;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_RACK = 3'b100
  } mmlc_state_type;
endpackage

// >>> mmlc_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mmlc_mem_if;
  logic [mmlc_pkg::MEM_AW-1:0] bus_addr;
  logic [7:0]                  bus_wdata;
  logic                        bus_we;
  logic [7:0]                  bus_rdata;
  logic [mmlc_pkg::MEM_AW-1:0] lut_addr;
  logic [7:0]                  lut_rdata;
  modport ctrl (output bus_addr, output bus_wdata, output bus_we, input bus_rdata,
                output lut_addr, input lut_rdata);
  modport mem  (input bus_addr, input bus_wdata, input bus_we, output bus_rdata,
                input lut_addr, output lut_rdata);
endinterface
`default_nettype wire

// >>> mmlc_mem.sv
`timescale 1ns/1ps
`default_nettype none
module mmlc_mem (
  input wire logic  i_ref_clk,
  input wire logic  i_rst_n,
  mmlc_mem_if.mem   mem
);
  localparam logic [mmlc_pkg::MEM_AW-1:0] ADDR_CELL = {mmlc_pkg::BLK_T1, mmlc_pkg::ADDR_OFS[6:0]};

  logic [7:0] mem_ff [mmlc_pkg::MEM_WORDS];
  logic [7:0] bus_rdata_ff;
  logic [7:0] lut_rdata_ff;

  // flop array so the power-on defaults are real; nonvolatile retention is outside this model
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < mmlc_pkg::MEM_WORDS; i++) begin
        mem_ff[i] <= (i == int'(ADDR_CELL)) ? mmlc_pkg::MAIN_DEV_DFLT : 8'h00;
      end
      bus_rdata_ff <= 8'h00;
      lut_rdata_ff <= 8'h00;
    end else begin
      if (mem.bus_we) begin
        mem_ff[mem.bus_addr] <= mem.bus_wdata;
      end
      bus_rdata_ff <= mem_ff[mem.bus_addr];
      lut_rdata_ff <= mem_ff[mem.lut_addr];
    end
  end

  assign mem.bus_rdata = bus_rdata_ff;
  assign mem.lut_rdata = lut_rdata_ff;
endmodule
`default_nettype wire

// >>> mmlc_lim_cmp.sv
`timescale 1ns/1ps
`default_nettype none
module mmlc_lim_cmp (
  input  wire logic        i_signed,
  input  wire logic [15:0] i_value,
  input  wire logic [15:0] i_high,
  input  wire logic [15:0] i_low,
  output logic             o_above,
  output logic             o_below
);
  always_comb begin
    if (i_signed) begin
      o_above = $signed(i_value) > $signed(i_high);
      o_below = $signed(i_value) < $signed(i_low);
    end else begin
      o_above = i_value > i_high;
      o_below = i_value < i_low;
    end
  end
endmodule
`default_nettype wire

// >>> mmlc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mmlc_checker (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       i_meas_valid,
  input wire logic       o_sda,
  input wire logic       o_sda_oe_n,
  input wire logic [7:0] o_res0_pos,
  input wire logic [7:0] o_res1_pos,
  input wire logic       o_manual_mode
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  reset_state_a: assert property (
    $rose(i_rst_n) |-> o_sda_oe_n && o_manual_mode && o_res0_pos == 8'h00 && o_res1_pos == 8'h00)
    else $error("outputs wrong after reset");
  open_drain_a: assert property (
    o_sda == 1'b0) else $error("sda output not zero");
  drive_scl_low_a: assert property (
    $changed(o_sda_oe_n) |-> !i_scl) else $error("sda drive moved while scl high");
  drive_ends_a: assert property (
    $fell(o_sda_oe_n) |-> ##[1:200] o_sda_oe_n) else $error("sda held low too long");
  stop_quiet_a: assert property (
    i_scl && $past(i_scl) && $rose(i_sda) |=> o_sda_oe_n [*6]) else $error("sda driven after stop");
  manual_hold_a: assert property (
    o_manual_mode && i_meas_valid |=> ($stable(o_res0_pos) && $stable(o_res1_pos)) [*3])
    else $error("manual position moved on measurement");
  manual_pos_a: assert property (
    o_manual_mode && $past(o_manual_mode) && ($changed(o_res0_pos) || $changed(o_res1_pos)) |-> !i_scl)
    else $error("manual position moved outside a write");
  mode_switch_a: assert property (
    $changed(o_manual_mode) |-> !i_scl) else $error("mode moved outside a write");
  cover property ($fell(o_sda_oe_n));
  cover property ($fell(o_manual_mode));
  cover property (!o_manual_mode && $changed(o_res0_pos));
endmodule
bind mmlc_top mmlc_checker chk_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
  .i_meas_valid(i_meas_valid), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_res0_pos(o_res0_pos),
  .o_res1_pos(o_res1_pos), .o_manual_mode(o_manual_mode));
`default_nettype wire

// >>> mmlc_host.sv
`timescale 1ns/1ps
`default_nettype none
module mmlc_host (
  input  wire logic i_ref_clk,
  input  wire logic i_oe_n,
  output logic      o_scl,
  output logic      o_sda
);
  logic sda_h = 1'b1;
  // released line rests at the pull-up level
  assign o_sda = i_oe_n ? sda_h : 1'b0;
  initial o_scl = 1'b1;
  task automatic wt();
    repeat (4) @(negedge i_ref_clk);
  endtask
  task automatic start();
    sda_h = 1'b1;
    wt();
    o_scl = 1'b1;
    wt();
    sda_h = 1'b0;
    wt();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    wt();
    sda_h = 1'b0;
    wt();
    o_scl = 1'b1;
    wt();
    sda_h = 1'b1;
    wt();
  endtask
  // nine bits, the last is the acknowledge slot; data moves a clock after scl falls
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      @(negedge i_ref_clk);
      sda_h = d[i];
      wt();
      o_scl = 1'b1;
      wt();
      r[i] = o_sda;
      o_scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, rst_n, scl, sda, oe_n, wp, mv, man, a;
  logic [15:0] tmp, vcc, e1, e2;
  logic [7:0]  p0, p1;
  logic [7:0]  mdl [0:1023];
  logic [7:0]  mo [7] = '{8'h60, 8'h62, 8'h64, 8'h66, 8'h68, 8'h70, 8'h74};
  logic [7:0]  dv = 8'ha2;
  logic [7:0]  tm [6] = '{8'hce, 8'hd8, 8'hda, 8'h3e, 8'h66, 8'h78};
  int          bad_count, samples_checked, tbl, x;
  mmlc_top uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe_n(oe_n),
    .i_write_protect_pin(wp), .i_meas_valid(mv), .i_temp(tmp), .i_vcc(vcc), .i_ext_input_one(e1),
    .i_ext_input_two(e2), .i_ext_input_three(e1), .o_res0_pos(p0), .o_res1_pos(p1), .o_manual_mode(man));
  mmlc_host host (.i_ref_clk(clk), .i_oe_n(oe_n), .o_scl(scl), .o_sda(sda));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1500000;
    bad_count++;
    report_and_stop();
  end
  function automatic int k(input logic [7:0] p);
    return (p >= 8'h80) ? tbl * 256 + int'(p) : int'(p);
  endfunction
  function automatic logic [15:0] lim(input int i);
    return {mdl[i], mdl[i + 1]};
  endfunction
  function automatic int ix(input logic [7:0] t);
    int y;
    y = $signed(t) + 40;
    return (y < 0) ? 0 : (y > 142) ? 71 : y / 2;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // the model follows only writes the device should take
  task automatic wrm(input logic [7:0] dev, input logic [7:0] p, input logic [7:0] d, input logic ok);
    logic [8:0] r;
    host.start();
    host.xfer({dev, 1'b1}, r);
    a = !r[0];
    if (a) begin
      host.xfer({p, 1'b1}, r);
      host.xfer({d, 1'b1}, r);
    end
    host.stop();
    if (ok) mdl[k(p)] = d;
    if (ok && p == 8'h7f) tbl = int'(d);
  endtask
  task automatic rdm(input logic [7:0] p);
    logic [8:0] r, s;
    host.start();
    host.xfer({dv, 1'b1}, r);
    host.xfer({p, 1'b1}, r);
    host.start();
    host.xfer({dv | 8'h01, 1'b1}, r);
    host.xfer(9'h1fe, r);
    host.xfer(9'h1ff, s);
    host.stop();
    chk("read pair", {mdl[k(p)], mdl[k(p + 8'h01)]}, {r[8:1], s[8:1]});
  endtask
  task automatic meas(input logic [15:0] t);
    tmp = t;
    {vcc, e1, e2} = {16'($urandom), 16'($urandom), 16'($urandom)};
    mv = 1'b1;
    @(negedge clk);
    mv = 1'b0;
    repeat (8) @(negedge clk);
    {mdl[8'h60], mdl[8'h61], mdl[8'h62], mdl[8'h63], mdl[8'h64], mdl[8'h65]} = {t, vcc, e1};
    // third external input shares the first one's stimulus
    {mdl[8'h66], mdl[8'h67], mdl[8'h68], mdl[8'h69]} = {e2, e1};
    mdl[8'h70] = {$signed(t) > $signed(lim(0)), $signed(t) < $signed(lim(2)), vcc > lim(8), vcc < lim(10),
      e1 > lim(16), 3'h0};
    mdl[8'h74] = {$signed(t) > $signed(lim(4)), $signed(t) < $signed(lim(6)), vcc > lim(12), vcc < lim(14), 4'h0};
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {rst_n, wp, mv, tmp, vcc, e1, e2} = '0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    x = $urandom(16);
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("positions", 16'h0000, {p0, p1});
    chk("manual", 16'h0001, {15'h0, man});
    for (int i = 0; i < 18; i += 2) rdm(8'(i));
    wrm(8'ha4, 8'h40, 8'h00, 0);
    chk("ack", 16'h0000, {15'h0, a});
    wrm(8'ha0, 8'h40, 8'h00, 0);
    chk("ack", 16'h0001, {15'h0, a});
    $display("test reset and address done");
    for (int i = 0; i < 18; i++) wrm(8'ha2, 8'(i), 8'($urandom), 1);
    for (int i = 0; i < 18; i += 2) rdm(8'(i));
    repeat (3) begin
      meas(16'($urandom));
      foreach (mo[j]) rdm(mo[j]);
    end
    $display("test limits done");
    wrm(8'ha2, 8'h7f, 8'h01, 1);
    wrm(8'ha2, 8'h89, 8'h10, 1);
    for (int i = 1; i >= 0; i--) begin
      wp = 1'(i);
      wrm(8'ha2, 8'h02, 8'($urandom), i == 0);
      wrm(8'ha2, 8'h60, 8'h5a, 0);
      rdm(8'h02);
      rdm(8'h60);
    end
    wrm(8'ha2, 8'h82, 8'($urandom), 1);
    wrm(8'ha2, 8'h83, 8'($urandom), 1);
    chk("manual positions", {mdl[k(8'h82)], mdl[k(8'h83)]}, {p0, p1});
    $display("test protect and manual done");
    for (int t = 2; t < 4; t++) begin
      wrm(8'ha2, 8'h7f, 8'(t), 1);
      foreach (tm[j]) wrm(8'ha2, 8'h80 + 8'(ix(tm[j])), 8'($urandom), 1);
    end
    wrm(8'ha2, 8'h7f, 8'h01, 1);
    wrm(8'ha2, 8'h89, 8'h11, 1);
    foreach (tm[j]) begin
      meas({tm[j], 8'($urandom)});
      chk("lut positions", {mdl[640 + ix(tm[j])], mdl[896 + ix(tm[j])]}, {p0, p1});
    end
    chk("manual", 16'h0000, {15'h0, man});
    wrm(8'ha2, 8'h89, 8'h15, 1);
    wrm(8'ha0, 8'h40, 8'h00, 0);
    chk("ack", 16'h0000, {15'h0, a});
    $display("test lut and single address done");
    wrm(8'ha2, 8'h8c, 8'hb4, 1);
    wrm(8'ha2, 8'h89, 8'h1f, 1);
    dv = 8'hb4;
    wrm(8'ha2, 8'h40, 8'h00, 0);
    chk("ack", 16'h0000, {15'h0, a});
    wrm(dv, 8'h7f, 8'h00, 1);
    chk("ack", 16'h0001, {15'h0, a});
    // pin is low, so only the aux protect bit can stop this write
    wrm(dv, 8'h80, 8'h3c, 0);
    rdm(8'h80);
    $display("test programmable address and aux protect done");
    report_and_stop();
  end
endmodule
`default_nettype wire
